// ### logic/can_cyc_pkg.sv
package can_cyc_pkg;

  // Sizes of the slot table and the trace store.
  localparam int NSLOT = 16;
  localparam int TRACE_DEPTH = 1024;
  localparam int ID_W = 28;
  localparam int DATA_W = 64;
  localparam int PER_W = 14;

  // Slot period limits in milliseconds, and the period after reset.
  localparam logic [13:0] PER_MIN_MS = 14'd25;
  localparam logic [13:0] PER_MAX_MS = 14'd9999;
  localparam logic [13:0] PER_RST = PER_MIN_MS;

  // Clock rate and the millisecond tick derived from it.
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 1000000;
  localparam int CYC_PER_MS = TICK_NS / CLK_NS;

  // Register byte offsets.
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_TIME = 12'h008;
  localparam logic [11:0] OFS_TIDX = 12'h00C;
  localparam logic [11:0] OFS_BITCYC = 12'h010;
  localparam logic [11:0] OFS_TR_ID = 12'h020;
  localparam logic [11:0] OFS_TR_DLO = 12'h024;
  localparam logic [11:0] OFS_TR_DHI = 12'h028;
  localparam logic [11:0] OFS_TR_TS = 12'h02C;
  // Slot block: base 0x200, 0x20 per slot, word index within the slot.
  localparam logic [2:0] SLOT_REGION = 3'h1;
  localparam logic [2:0] SR_CFG = 3'h0;
  localparam logic [2:0] SR_ID = 3'h1;
  localparam logic [2:0] SR_DLO = 3'h2;
  localparam logic [2:0] SR_DHI = 3'h3;
  localparam logic [2:0] SR_PER = 3'h4;

  // Control register fields.
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_RX_EN = 1;
  localparam int CTRL_MODE = 2;
  localparam int CTRL_CLR = 3;
  localparam int CTRL_RATE_LSB = 4;
  // Slot config fields.
  localparam int CFG_EN = 0;
  localparam int CFG_EXT = 1;
  localparam int CFG_RTR = 2;
  localparam int CFG_NDIG_LSB = 8;
  localparam logic [4:0] NDIG_MAX = 5'd16;

  // Bit rate selection: codes 0..8 for 10K up to 1000K.
  localparam logic [3:0] RATE_MAX = 4'h8;
  localparam logic [3:0] RATE_RST = 4'h0;
  function automatic logic [13:0] bit_cyc(input int kbps);
    return 14'(1000000 / (CLK_NS * kbps));
  endfunction
  localparam logic [13:0] BIT_CYC [9] = '{bit_cyc(10), bit_cyc(20),
    bit_cyc(50), bit_cyc(100), bit_cyc(125), bit_cyc(250), bit_cyc(500),
    bit_cyc(800), bit_cyc(1000)};

  // One frame as handed to or taken from the bit engine.
  typedef struct packed {
    logic [27:0] id;
    logic ext;
    logic rtr;
    logic [3:0] dlc;
    logic [63:0] data;
  } can_frame_t;

  // One trace entry: the frame and its time field in ms.
  typedef struct packed {
    can_frame_t frame;
    logic [31:0] stamp;
  } trace_entry_t;

  typedef enum logic [1:0] {
    TR_IDLE = 2'b00,
    TR_SCAN = 2'b01,
    TR_STORE = 2'b10
  } trace_st_t;

endpackage

// ### logic/ms_tick.sv
`timescale 1ns/1ps
module ms_tick #(
  parameter int CYCLES = 100000
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic tick
);
  logic [31:0] cnt_q;

  // Free-running divider; tick is one cycle wide per period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 32'h0;
    end else if (cnt_q == 32'(CYCLES - 1)) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  assign tick = (cnt_q == 32'(CYCLES - 1));
endmodule

// ### logic/frame_buf2.sv
`timescale 1ns/1ps
module frame_buf2 #(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [W-1:0] mem_q [2];
  logic wp_q;
  logic rp_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage words carry no reset; only the pointers matter.
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  // Pointers and fill level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + 2'(push) - 2'(pop);
    end
  end
endmodule

// ### logic/can_cyclic_tx_rx_trace.sv
// Overview of operation
// R01 - Sixteen transmit slots, each with enable, id, data, flags, period.
// R02 - A slot sends repeatedly only while its enable and loop enable are set.
// R03 - Each slot holds a 28-bit id used as the frame id.
// R04 - Payload up to 64 bits; length code is hex digits halved, rounded up.
// R05 - An odd last digit fills the upper nibble; lower nibble is zero.
// R06 - Extended flag set means the frame uses the extended id format.
// R07 - Remote flag set means the slot goes out as a remote frame.
// R08 - Period is 25 to 9999 ms; one transmission per elapsed period.
// R09 - Received frames go into a 1024-entry trace only while rx enabled.
// R10 - Bit rate selectable only among nine fixed rates, 10K to 1000K.
// R11 - Delta mode keeps one entry per id with time since its last frame.
// R12 - Full mode appends every frame with an absolute time stamp.
// R13 - Full mode wraps its write pointer and overwrites the oldest entry.
// R14 - Slot periods and time stamps come from one millisecond tick.
`timescale 1ns/1ps
module can_cyclic_tx_rx_trace #(
  parameter int TICK_CYCLES = can_cyc_pkg::CYC_PER_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output can_cyc_pkg::can_frame_t tx_frame,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire can_cyc_pkg::can_frame_t rx_frame,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic [3:0] rate_sel,
  output logic [13:0] bit_cycles
);
  import can_cyc_pkg::*;

  // Slot table.
  logic [NSLOT-1:0] en_q;
  logic [NSLOT-1:0] ext_q;
  logic [NSLOT-1:0] rtr_q;
  logic [4:0] ndig_q [NSLOT];
  logic [ID_W-1:0] id_q [NSLOT];
  logic [DATA_W-1:0] dat_q [NSLOT];
  logic [PER_W-1:0] per_q [NSLOT];
  logic [PER_W-1:0] cnt_q [NSLOT];
  logic [NSLOT-1:0] pend_q;
  logic [NSLOT-1:0] due;

  // Global control.
  logic tx_en_q;
  logic rx_en_q;
  logic mode_full_q;
  logic [3:0] rate_q;
  logic [13:0] bitcyc_q;
  logic [9:0] tidx_q;
  logic [31:0] now_q;
  logic tick;

  // Trace store and its walker.
  trace_entry_t mem_q [TRACE_DEPTH];
  logic [31:0] last_q [TRACE_DEPTH];
  trace_st_t st_q;
  can_frame_t rxf_q;
  logic [31:0] rxt_q;
  logic [9:0] scan_q;
  logic [9:0] sidx_q;
  logic [31:0] stamp_q;
  logic new_q;
  logic [10:0] count_q;
  logic [9:0] wptr_q;
  trace_entry_t scan_ent;
  trace_entry_t rd_ent;
  logic id_match;
  logic rx_take;
  logic trace_clr;

  // Bus decode.
  logic setup;
  logic access;
  logic in_slots;
  logic [3:0] sidx;
  logic [2:0] sreg;
  logic addr_ok;
  logic wr;
  logic wr_ctrl;
  logic [31:0] rd_val;
  logic [31:0] prdata_q;

  // Transmit path.
  logic [3:0] sel;
  logic push;
  logic buf_ready;
  can_frame_t push_frame;

  // Packs right-aligned hex digits so the first digit lands in the upper
  // nibble of byte 0; a missing last digit leaves a zero lower nibble.
  function automatic logic [63:0] pack_data(input logic [63:0] d,
                                            input logic [4:0] n);
    logic [63:0] r;
    int pos;
    r = 64'h0;
    pos = 0;
    for (int i = 0; i < 16; i++) begin
      if (5'(i) < n) begin
        pos = int'(n) - 1 - i;
        r[4*(i^1) +: 4] = d[4*pos +: 4]; // [R05]
      end
    end
    return r;
  endfunction

  ms_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  // One millisecond time base shared by slots and trace stamps.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      now_q <= 32'h0;
    end else if (tick) begin
      now_q <= now_q + 32'h1; // [R14]
    end
  end

  // APB decode; the slave always answers in the first access cycle.
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign in_slots = (paddr[11:9] == SLOT_REGION);
  assign sidx = paddr[8:5];
  assign sreg = paddr[4:2];
  always_comb begin
    addr_ok = 1'b0;
    if (in_slots) begin
      addr_ok = (sreg <= SR_PER) & (paddr[1:0] == 2'b00);
    end else begin
      unique case (paddr)
        OFS_CTRL, OFS_STATUS, OFS_TIME, OFS_TIDX, OFS_BITCYC,
        OFS_TR_ID, OFS_TR_DLO, OFS_TR_DHI, OFS_TR_TS: addr_ok = 1'b1;
        default: addr_ok = 1'b0;
      endcase
    end
  end
  assign pready = access;
  assign pslverr = access & ~addr_ok;
  assign wr = access & pwrite & addr_ok;
  assign wr_ctrl = wr & ~in_slots & (paddr == OFS_CTRL);
  // A mode change empties the trace, since the two layouts do not mix.
  assign trace_clr = wr_ctrl & (pwdata[CTRL_CLR] |
                     (pwdata[CTRL_MODE] != mode_full_q));

  // Global control register and trace read index.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_en_q <= 1'b0;
      rx_en_q <= 1'b0;
      mode_full_q <= 1'b0;
      rate_q <= RATE_RST;
      bitcyc_q <= BIT_CYC[RATE_RST];
      tidx_q <= 10'h0;
    end else begin
      if (wr_ctrl) begin
        tx_en_q <= pwdata[CTRL_TX_EN];
        rx_en_q <= pwdata[CTRL_RX_EN];
        mode_full_q <= pwdata[CTRL_MODE];
        // Codes beyond the nine rates are ignored.
        if (pwdata[CTRL_RATE_LSB +: 4] <= RATE_MAX) begin // [R10]
          rate_q <= pwdata[CTRL_RATE_LSB +: 4];
          bitcyc_q <= BIT_CYC[pwdata[CTRL_RATE_LSB +: 4]]; // [R10]
        end
      end
      if (wr & ~in_slots & (paddr == OFS_TIDX)) begin
        tidx_q <= pwdata[9:0];
      end
    end
  end
  assign rate_sel = rate_q;
  assign bit_cycles = bitcyc_q;

  // Slot registers; out-of-range periods and digit counts are ignored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= '0;
      ext_q <= '0;
      rtr_q <= '0;
      for (int s = 0; s < NSLOT; s++) begin
        ndig_q[s] <= 5'h0;
        id_q[s] <= 28'h0;
        dat_q[s] <= 64'h0;
        per_q[s] <= PER_RST;
      end
    end else if (wr & in_slots) begin
      unique case (sreg)
        SR_CFG: begin
          en_q[sidx] <= pwdata[CFG_EN]; // [R01]
          ext_q[sidx] <= pwdata[CFG_EXT]; // [R06]
          rtr_q[sidx] <= pwdata[CFG_RTR]; // [R07]
          if (pwdata[CFG_NDIG_LSB +: 5] <= NDIG_MAX) begin
            ndig_q[sidx] <= pwdata[CFG_NDIG_LSB +: 5]; // [R04]
          end
        end
        SR_ID: id_q[sidx] <= pwdata[ID_W-1:0]; // [R03]
        SR_DLO: dat_q[sidx][31:0] <= pwdata;
        SR_DHI: dat_q[sidx][63:32] <= pwdata;
        SR_PER: begin
          if (pwdata[31:PER_W] == '0 && pwdata[PER_W-1:0] >= PER_MIN_MS &&
              pwdata[PER_W-1:0] <= PER_MAX_MS) begin
            per_q[sidx] <= pwdata[PER_W-1:0]; // [R08]
          end
        end
        default: begin
        end
      endcase
    end
  end

  // A slot falls due when its elapsed count reaches its period.
  always_comb begin
    for (int s = 0; s < NSLOT; s++) begin
      due[s] = en_q[s] & tx_en_q & tick &
               (cnt_q[s] + 14'h1 >= per_q[s]); // [R08]
    end
  end

  // Per-slot elapsed counters, held at zero while the slot is idle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int s = 0; s < NSLOT; s++) begin
        cnt_q[s] <= 14'h0;
      end
    end else begin
      for (int s = 0; s < NSLOT; s++) begin
        if (!(en_q[s] & tx_en_q)) begin
          cnt_q[s] <= 14'h0; // [R02]
        end else if (due[s]) begin
          cnt_q[s] <= 14'h0;
        end else if (tick) begin
          cnt_q[s] <= cnt_q[s] + 14'h1; // [R14]
        end
      end
    end
  end

  // Pending flags; a fresh due wins over the clear by a push.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= '0;
    end else begin
      for (int s = 0; s < NSLOT; s++) begin
        if (!(en_q[s] & tx_en_q)) begin
          pend_q[s] <= 1'b0; // [R02]
        end else if (due[s]) begin
          pend_q[s] <= 1'b1; // [R02]
        end else if (push && sel == 4'(s)) begin
          pend_q[s] <= 1'b0;
        end
      end
    end
  end

  // Lowest pending slot goes first; periods are long, so none starves.
  always_comb begin
    sel = 4'h0;
    for (int s = NSLOT - 1; s >= 0; s--) begin
      if (pend_q[s]) begin
        sel = 4'(s);
      end
    end
  end

  // Frame assembly; a remote frame carries its length but no data.
  always_comb begin
    push_frame.id = id_q[sel]; // [R03]
    push_frame.ext = ext_q[sel]; // [R06]
    push_frame.rtr = rtr_q[sel]; // [R07]
    push_frame.dlc = 4'((ndig_q[sel] + 5'h1) >> 1); // [R04]
    push_frame.data = rtr_q[sel] ? 64'h0 :
                      pack_data(dat_q[sel], ndig_q[sel]);
  end
  assign push = (|pend_q) & buf_ready;

  // Two-entry buffer lets the bit engine stall without losing a frame.
  frame_buf2 #(
    .W($bits(can_frame_t))
  ) u_txbuf (
    .pclk(pclk),
    .presetn(presetn),
    .in_data(push_frame),
    .in_valid(|pend_q),
    .in_ready(buf_ready),
    .out_data(tx_frame),
    .out_valid(tx_valid),
    .out_ready(tx_ready)
  );

  // Receive side: one frame is taken at a time while the walker idles.
  assign rx_ready = (st_q == TR_IDLE);
  assign rx_take = rx_valid & rx_ready & rx_en_q; // [R09]
  assign scan_ent = mem_q[scan_q];
  assign id_match = (scan_ent.frame.id == rxf_q.id) &
                    (scan_ent.frame.ext == rxf_q.ext);

  // Trace walker: full mode stores at once, delta mode searches first.
  // The search costs one cycle per stored id, up to 1024 cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= TR_IDLE;
      rxf_q <= '0;
      rxt_q <= 32'h0;
      scan_q <= 10'h0;
      sidx_q <= 10'h0;
      stamp_q <= 32'h0;
      new_q <= 1'b0;
      count_q <= 11'h0;
      wptr_q <= 10'h0;
    end else if (trace_clr) begin
      st_q <= TR_IDLE;
      count_q <= 11'h0;
      wptr_q <= 10'h0;
    end else begin
      unique case (st_q)
        TR_IDLE: begin
          if (rx_take) begin
            rxf_q <= rx_frame;
            rxt_q <= now_q;
            scan_q <= 10'h0;
            if (mode_full_q) begin
              sidx_q <= wptr_q; // [R12]
              stamp_q <= now_q; // [R12]
              new_q <= (count_q != 11'(TRACE_DEPTH));
              wptr_q <= wptr_q + 10'h1; // [R13]
              st_q <= TR_STORE;
            end else if (count_q == 11'h0) begin
              sidx_q <= 10'h0;
              stamp_q <= 32'h0;
              new_q <= 1'b1;
              st_q <= TR_STORE;
            end else begin
              st_q <= TR_SCAN;
            end
          end
        end
        TR_SCAN: begin
          if (id_match) begin
            sidx_q <= scan_q; // [R11]
            stamp_q <= rxt_q - last_q[scan_q]; // [R11]
            new_q <= 1'b0;
            st_q <= TR_STORE;
          end else if ({1'b0, scan_q} == count_q - 11'h1) begin
            // A new id with the table full is dropped.
            if (count_q != 11'(TRACE_DEPTH)) begin
              sidx_q <= count_q[9:0]; // [R11]
              stamp_q <= 32'h0;
              new_q <= 1'b1;
              st_q <= TR_STORE;
            end else begin
              st_q <= TR_IDLE;
            end
          end else begin
            scan_q <= scan_q + 10'h1;
          end
        end
        TR_STORE: begin
          if (new_q) begin
            count_q <= count_q + 11'h1;
          end
          st_q <= TR_IDLE;
        end
        default: st_q <= TR_IDLE;
      endcase
    end
  end

  // Trace memory write; entries hold no reset, count marks what is valid.
  always_ff @(posedge pclk) begin
    if (st_q == TR_STORE) begin
      mem_q[sidx_q] <= '{frame: rxf_q, stamp: stamp_q}; // [R09]
      last_q[sidx_q] <= rxt_q; // [R11]
    end
  end

  // Read mux, sampled in the setup cycle so data comes from a flop.
  assign rd_ent = mem_q[tidx_q];
  always_comb begin
    rd_val = 32'h0;
    if (in_slots) begin
      unique case (sreg)
        SR_CFG: rd_val = {19'h0, ndig_q[sidx], 5'h0, rtr_q[sidx],
                          ext_q[sidx], en_q[sidx]};
        SR_ID: rd_val = {4'h0, id_q[sidx]};
        SR_DLO: rd_val = dat_q[sidx][31:0];
        SR_DHI: rd_val = dat_q[sidx][63:32];
        SR_PER: rd_val = {18'h0, per_q[sidx]};
        default: rd_val = 32'h0;
      endcase
    end else begin
      unique case (paddr)
        OFS_CTRL: rd_val = {24'h0, rate_q, 1'b0, mode_full_q, rx_en_q,
                            tx_en_q};
        OFS_STATUS: rd_val = {st_q != TR_IDLE, 4'h0, count_q, 6'h0, wptr_q};
        OFS_TIME: rd_val = now_q;
        OFS_TIDX: rd_val = {22'h0, tidx_q};
        OFS_BITCYC: rd_val = {18'h0, bitcyc_q};
        OFS_TR_ID: rd_val = {rd_ent.frame.ext, rd_ent.frame.rtr,
                             rd_ent.frame.dlc[1:0], rd_ent.frame.id};
        OFS_TR_DLO: rd_val = rd_ent.frame.data[31:0];
        OFS_TR_DHI: rd_val = rd_ent.frame.data[63:32];
        OFS_TR_TS: rd_val = rd_ent.stamp;
        default: rd_val = 32'h0;
      endcase
    end
  end

  // Read data register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (setup & ~pwrite) begin
      prdata_q <= rd_val;
    end
  end
  assign prdata = prdata_q;
endmodule

// ### tb/can_cyc_asserts.sv
`timescale 1ns/1ps
module can_cyc_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire can_cyc_pkg::can_frame_t tx_frame,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire can_cyc_pkg::can_frame_t rx_frame,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [3:0] rate_sel,
  input wire logic [13:0] bit_cycles
);
  import can_cyc_pkg::*;
  // Bit length in clocks for each rate code, slowest rate first.
  localparam logic [13:0] CYC_TAB [9] = '{14'h2710, 14'h1388, 14'h07D0,
    14'h03E8, 14'h0320, 14'h0190, 14'h00C8, 14'h007D, 14'h0064};

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // An access cycle, and a frame offered to a node that is not taking it.
  sequence apb_access;
    psel && penable;
  endsequence
  sequence tx_stalled;
    tx_valid && !tx_ready;
  endsequence

  no_wait_a: assert property (apb_access |-> pready)
    else $error("pready missing in access cycle");
  err_in_access_a: assert property (pslverr |-> apb_access)
    else $error("pslverr outside an access cycle");
  tx_hold_a: assert property (tx_stalled |=> tx_valid && $stable(tx_frame))
    else $error("stalled frame changed or vanished");
  dlc_limit_a: assert property (tx_valid |-> tx_frame.dlc <= 4'h8)
    else $error("length code above eight");
  remote_empty_a: assert property (
    tx_valid && tx_frame.rtr |-> tx_frame.data == 64'h0)
    else $error("remote frame carries data");
  rate_legal_a: assert property (rate_sel <= 4'h8)
    else $error("rate code out of range");
  rate_cycles_a: assert property (
    $stable(rate_sel) |-> bit_cycles == CYC_TAB[rate_sel])
    else $error("bit length does not match rate");
  // Busy cycles of the trace walker; a full delta search needs 1025 at most.
  logic [10:0] busy_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt <= 11'h0;
    end else if (rx_ready) begin
      busy_cnt <= 11'h0;
    end else begin
      busy_cnt <= busy_cnt + 11'h1;
    end
  end
  walker_back_a: assert property (busy_cnt <= 11'd1100)
    else $error("trace walker stuck busy");
endmodule

bind can_cyclic_tx_rx_trace can_cyc_asserts chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tx_frame(tx_frame),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_frame(rx_frame),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .rate_sel(rate_sel),
  .bit_cycles(bit_cycles));

// ### tb/can_bus_node.sv
`timescale 1ns/1ps
module can_bus_node (
  input wire logic pclk,
  input wire can_cyc_pkg::can_frame_t tx_frame,
  input wire logic tx_valid,
  output logic tx_ready,
  output can_cyc_pkg::can_frame_t rx_frame,
  output logic rx_valid,
  input wire logic rx_ready
);
  import can_cyc_pkg::*;
  typedef struct {can_frame_t f; int t;} seen_t;
  seen_t log[$];
  int cyc = 0;
  logic hold = 1'b0;
  logic slow = 1'b0;

  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_frame = '0;
  end

  // Log each frame taken; slow mode takes only every other cycle.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (tx_valid && tx_ready) begin
      log.push_back('{tx_frame, cyc});
    end
    tx_ready <= !hold && !(slow && tx_ready);
  end

  // Offers one frame and holds it until the block takes it.
  task automatic send(input can_frame_t f);
    @(posedge pclk);
    rx_frame <= f;
    rx_valid <= 1'b1;
    do @(posedge pclk); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
    rx_frame <= ~f; // A released bus must not look like the last frame.
  endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import can_cyc_pkg::*;
  localparam int TK = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  can_frame_t tx_frame;
  can_frame_t rx_frame;
  logic tx_valid;
  logic tx_ready;
  logic rx_valid;
  logic rx_ready;
  logic [3:0] rate_sel;
  logic [13:0] bit_cycles;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  logic [31:0] rv;
  logic [31:0] ts;
  logic err;
  int kb[9] = '{10, 20, 50, 100, 125, 250, 500, 800, 1000};

  always #5 pclk = ~pclk;

  can_cyclic_tx_rx_trace #(.TICK_CYCLES(TK)) uut (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_frame(tx_frame), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_frame(rx_frame), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rate_sel(rate_sel), .bit_cycles(bit_cycles));
  can_bus_node node (.pclk(pclk), .tx_frame(tx_frame),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_frame(rx_frame),
    .rx_valid(rx_valid), .rx_ready(rx_ready));

  task summarize;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input string nm, input logic [127:0] s, input logic [127:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [11:0] sa(input int s, input logic [2:0] r);
    return {SLOT_REGION, 9'h000} + 12'(s * 32) + 12'(r * 4);
  endfunction

  function automatic can_frame_t mkf(input logic [27:0] id);
    return {id, 1'b0, 1'b0, 4'h8, {2{id, 4'h5}}};
  endfunction

  task wait_tx(input int k);
    repeat (2000) if (node.log.size() < k) @(posedge pclk);
  endtask

  // A hang costs a mismatch and ends the run through the report.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFS_CTRL, 0);
    chk("ctrl", rv, 0);
    apb(0, sa(4, SR_PER), 0);
    chk("period reset", rv, 25);
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      apb(1, OFS_CTRL, i << 4);
      apb(0, OFS_BITCYC, 0);
      chk("bit cycles", rv, 100000 / kb[i]);
      chk("rate sel", rate_sel, i);
    end
    apb(1, OFS_CTRL, 32'h90);
    apb(0, OFS_CTRL, 0);
    chk("bad rate", rate_sel, 8);
    $display("test rates done");
    apb(1, 12'hFF0, 32'h1);
    chk("unmapped", err, 1);
    apb(1, sa(15, SR_ID), 32'hABCDEF1);
    apb(0, sa(15, SR_ID), 0);
    chk("slot 15 id", rv, 32'hABCDEF1);
    apb(1, sa(4, SR_PER), 24);
    apb(1, sa(4, SR_PER), 10000);
    apb(0, sa(4, SR_PER), 0);
    chk("period limits", rv, 25);
    apb(1, sa(4, SR_PER), 9999);
    apb(0, sa(4, SR_PER), 0);
    chk("period max", rv, 9999);
    $display("test registers done");
    apb(1, sa(1, SR_ID), 32'h1E);
    apb(1, sa(1, SR_DLO), 32'h14);
    apb(1, sa(1, SR_CFG), 32'h205);
    apb(1, sa(2, SR_ID), 32'h2);
    apb(1, sa(2, SR_DLO), 32'hAB);
    apb(1, sa(2, SR_CFG), 32'h1);
    apb(1, sa(3, SR_ID), 32'hFFFFFFF);
    apb(1, sa(3, SR_DLO), 32'hFFA0129);
    apb(1, sa(3, SR_CFG), 32'h703);
    repeat (600) @(posedge pclk);
    chk("loop off", node.log.size(), 0);
    apb(1, OFS_CTRL, 32'h1);
    wait_tx(6);
    chk("remote", node.log[0].f, {28'h1E, 2'b01, 4'h1, 64'h0});
    chk("empty dlc", node.log[1].f.dlc, 0);
    chk("ext frame", node.log[2].f,
      {28'hFFFFFFF, 2'b10, 4'h4, 64'h9012A0FF});
    chk("period", node.log[3].t - node.log[0].t, 25 * TK);
    $display("test transmit done");
    n = node.log.size();
    @(posedge pclk);
    node.hold <= 1'b1;
    node.slow <= 1'b1;
    repeat (1100) @(posedge pclk);
    node.hold <= 1'b0;
    wait_tx(n + 2);
    chk("stall first", node.log[n].f.id, 28'h1E);
    chk("stall second", node.log[n + 1].f.id, 28'h2);
    apb(1, OFS_CTRL, 0);
    repeat (20) @(posedge pclk);
    n = node.log.size();
    repeat (600) @(posedge pclk);
    chk("loop stopped", node.log.size(), n);
    $display("test stall done");
    node.send(mkf(28'h7));
    apb(0, OFS_STATUS, 0);
    chk("rx off", rv[26:16], 0);
    apb(1, OFS_CTRL, 32'h6);
    for (int i = 1; i <= 1025; i++) node.send(mkf(28'(i)));
    apb(0, OFS_STATUS, 0);
    chk("wptr", rv[9:0], 1);
    chk("count", rv[26:16], 1024);
    apb(1, OFS_TIDX, 0);
    apb(0, OFS_TR_ID, 0);
    chk("overwrite", rv[27:0], 28'h401);
    apb(0, OFS_TR_TS, 0);
    ts = rv;
    apb(0, OFS_TIME, 0);
    chk("abs stamp", rv >= ts && rv - ts <= 2 && ts > 100, 1);
    apb(1, OFS_CTRL, 32'hE);
    apb(0, OFS_STATUS, 0);
    chk("trace clear", rv[26:0], 0);
    $display("test full trace done");
    apb(1, OFS_CTRL, 32'h2);
    node.send(mkf(28'h5));
    node.send(mkf(28'h6));
    repeat (3 * TK) @(posedge pclk);
    node.send(mkf(28'h5));
    apb(0, OFS_STATUS, 0);
    chk("ids", rv[26:16], 2);
    apb(1, OFS_TIDX, 0);
    apb(0, OFS_TR_ID, 0);
    chk("delta id", rv[27:0], 28'h5);
    apb(0, OFS_TR_TS, 0);
    chk("delta time", rv >= 2 && rv <= 4, 1);
    apb(1, OFS_TIDX, 1);
    apb(0, OFS_TR_TS, 0);
    chk("first time", rv, 0);
    $display("test delta trace done");
    summarize();
  end
endmodule
